/* hdl/tpc_pwm_gen.sv */
// Three-phase PWM generator with preloaded compares and output chopper.
// Assumes an AXI4-Lite master on the same 10 MHz clock, synchronous reset.
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Two-bit target picks chopped high/low channels
// - Three-bit code picks chop frequency, halvable
// - Complementary pairs fixed; chopper per target only
// - Three phases share one carrier period
// - Single mode routes phase U only
// - One 12-bit counter, 13-bit phase compares
// - Compares preloaded, transferred only on update
// - Buffered prescaler divides clock by 1..8
// - Center mode counts up then down
// - Center: low on up-match, high on down-match
// - Edge mode counts up, then clears
// - Edge: low on match, high on clear
// - Counter zero-extended to 13-bit compare
// - Above carrier holds high, zero holds low
// - Low byte first; high byte arms transfer
// - Byte mode with per-phase force, cleared on update
// - Reads return preload contents
// - Left-aligned 16-bit value rounded to 13 bits
// - Stopped at zero until enabled; enable forces update
// - Update on wrap when repetition count is zero
// - Update flag raised with update event
module tpc_pwm_gen import tpc_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire tpc_axil_req_t axi_req_i,
	output var tpc_axil_rsp_t axi_rsp_o,
	output var logic [2:0] phase_o,
	output var logic [5:0] motor_output_channel_o,
	output var logic update_event_o,
	output var logic update_interrupt_flag_o
);

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [12:0] round13(input logic [15:0] v);
		logic [13:0] s;
		s = {1'b0, v[15:3]} + {13'h0000, v[2]};
		round13 = s[13] ? 13'h1FFF : s[12:0];
	endfunction

	function automatic logic phase_level(input logic [12:0] cmp, input logic [11:0] cnt,
			input logic down, input logic force_full);
		logic [12:0] c13;
		c13 = {1'b0, cnt};
		if (force_full) begin
			phase_level = 1'b1;
		end else if (cmp == 13'h0000) begin
			phase_level = 1'b0;
		end else if (down) begin
			phase_level = (c13 <= cmp);
		end else begin
			phase_level = (c13 < cmp);
		end
	endfunction

	function automatic logic [31:0] cmp_addr(input int idx, input logic high);
		cmp_addr = OFS_CMP_BASE + 32'(idx) * OFS_CMP_STRIDE + (high ? OFS_CMP_HIGH : 32'h0000_0000);
	endfunction

	// ****************************************
	// Bus slave
	// ****************************************
	logic aw_full, w_full, bvalid, rvalid;
	logic [31:0] aw_addr, w_data, rdata;
	logic [3:0] w_strb;
	logic [1:0] bresp, rresp;
	logic [31:0] rd_word;
	logic rd_hit;

	wire logic awready = !aw_full && !bvalid;
	wire logic wready = !w_full && !bvalid;
	wire logic arready = !rvalid;
	wire logic wr_fire = aw_full && w_full && !bvalid;
	wire logic wr_b0 = wr_fire && w_strb[0];
	wire logic wr_ctrl = wr_b0 && (aw_addr == OFS_CTRL);
	wire logic wr_pwc = wr_b0 && (aw_addr == OFS_PWM_CONTROL);
	wire logic wr_chop = wr_b0 && (aw_addr == OFS_CHOPPER);
	wire logic wr_rep = wr_b0 && (aw_addr == OFS_REPETITION);
	wire logic wr_status = wr_b0 && (aw_addr == OFS_STATUS);
	logic [3:0] wr_lo, wr_hi;
	logic wr_cmp_hit;

	always_comb begin
		wr_lo = 4'h0;
		wr_hi = 4'h0;
		for (int i = 0; i < 4; i++) begin
			wr_lo[i] = wr_b0 && (aw_addr == cmp_addr(i, 1'b0));
			wr_hi[i] = wr_b0 && (aw_addr == cmp_addr(i, 1'b1));
		end
	end

	always_comb begin
		wr_cmp_hit = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (aw_addr == cmp_addr(i, 1'b0) || aw_addr == cmp_addr(i, 1'b1)) begin
				wr_cmp_hit = 1'b1;
			end
		end
	end

	wire logic wr_hit = wr_cmp_hit || aw_addr == OFS_CTRL || aw_addr == OFS_PWM_CONTROL
		|| aw_addr == OFS_CHOPPER || aw_addr == OFS_REPETITION || aw_addr == OFS_STATUS
		|| aw_addr == OFS_COUNTER;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			bvalid <= 1'b0;
			aw_addr <= 32'h0000_0000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bresp <= RESP_OKAY;
		end else begin
			if (axi_req_i.awvalid && awready) begin
				aw_full <= 1'b1;
				aw_addr <= axi_req_i.awaddr;
			end
			if (axi_req_i.wvalid && wready) begin
				w_full <= 1'b1;
				w_data <= axi_req_i.wdata;
				w_strb <= axi_req_i.wstrb;
			end
			if (wr_fire) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && axi_req_i.bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else if (axi_req_i.arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && axi_req_i.rready) begin
			rvalid <= 1'b0;
		end
	end

	assign axi_rsp_o = '{awready: awready, wready: wready, bvalid: bvalid, bresp: bresp,
		arready: arready, rvalid: rvalid, rdata: rdata, rresp: rresp};

	// ****************************************
	// Registers
	// ****************************************
	logic [CTRL_W-1:0] ctrl;
	logic [7:0] pwc_pre;
	logic [4:0] chop_cfg;
	logic [7:0] rep_pre, rep_act, rep_cnt;
	logic [7:0] cmp_lo [4];
	logic [7:0] cmp_hi [4];
	logic [12:0] cmp_act [4];
	logic [3:0] armed;
	logic [2:0] presc_act;
	logic center_act, byte_act, clk_en_q, upd_flag;
	logic [11:0] cnt;
	logic [2:0] pc;
	tpc_dir_t dir;
	logic upd;

	wire logic clk_en = ctrl[CTRL_CLK_EN];
	wire logic three_sig = ctrl[CTRL_THREE_SIGNAL];
	wire logic [2:0] force_bits = pwc_pre[PWC_FORCE_LSB +: 3];
	wire logic [1:0] chop_target = chop_cfg[CHOP_TGT_HI:CHOP_TGT_LO];
	wire logic [11:0] carrier = cmp_act[0][11:0];

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			ctrl <= CTRL_RST;
			pwc_pre <= PWC_RST;
			chop_cfg <= CHOP_RST;
			rep_pre <= REP_RST;
		end else begin
			if (wr_ctrl) ctrl <= w_data[CTRL_W-1:0];
			if (wr_chop) chop_cfg <= w_data[4:0];
			if (wr_rep) rep_pre <= w_data[7:0];
			if (wr_pwc) begin
				pwc_pre <= w_data[7:0];
			end else if (upd) begin
				pwc_pre[PWC_FORCE_LSB +: 3] <= 3'h0;
			end
		end
	end

	// Low write disarms so a half-written pair never transfers
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			armed <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				cmp_lo[i] <= CMP_BYTE_RST;
				cmp_hi[i] <= CMP_BYTE_RST;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (wr_lo[i]) begin
					cmp_lo[i] <= w_data[7:0];
					armed[i] <= 1'b0;
				end
				if (wr_hi[i]) begin
					cmp_hi[i] <= w_data[7:0];
					armed[i] <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			upd_flag <= 1'b0;
		end else if (upd && ctrl[CTRL_UPD_IE]) begin
			upd_flag <= 1'b1;
		end else if (wr_status && w_data[0]) begin
			upd_flag <= 1'b0;
		end
	end

	always_comb begin
		rd_hit = 1'b1;
		rd_word = 32'h0000_0000;
		if (axi_req_i.araddr == OFS_CTRL) begin
			rd_word = {27'h0000000, ctrl};
		end else if (axi_req_i.araddr == OFS_PWM_CONTROL) begin
			rd_word = {24'h000000, pwc_pre};
		end else if (axi_req_i.araddr == OFS_CHOPPER) begin
			rd_word = {27'h0000000, chop_cfg};
		end else if (axi_req_i.araddr == OFS_REPETITION) begin
			rd_word = {24'h000000, rep_pre};
		end else if (axi_req_i.araddr == OFS_STATUS) begin
			rd_word = {31'h00000000, upd_flag};
		end else if (axi_req_i.araddr == OFS_COUNTER) begin
			rd_word = {20'h00000, cnt};
		end else begin
			rd_hit = 1'b0;
			for (int i = 0; i < 4; i++) begin
				if (axi_req_i.araddr == cmp_addr(i, 1'b0)) begin
					rd_word = {24'h000000, cmp_lo[i]};
					rd_hit = 1'b1;
				end
				if (axi_req_i.araddr == cmp_addr(i, 1'b1)) begin
					rd_word = {24'h000000, cmp_hi[i]};
					rd_hit = 1'b1;
				end
			end
		end
	end

	// ****************************************
	// Counter and update events
	// ****************************************
	wire logic tick = clk_en && (pc == presc_act);
	wire logic at_top = (cnt >= carrier);
	wire logic at_bottom = (cnt == 12'h000);
	wire logic wrap = tick && ((dir == DIR_UP && at_top) || (dir == DIR_DOWN && at_bottom));
	wire logic start = clk_en && !clk_en_q;
	assign upd = start || (wrap && rep_cnt == 8'h00);

	always_ff @(posedge ref_clk_i) begin
		if (srst_i || !clk_en) begin
			cnt <= 12'h000;
			pc <= 3'h0;
			dir <= DIR_UP;
		end else begin
			pc <= tick ? 3'h0 : 3'(pc + 3'h1);
			if (tick) begin
				case (dir)
					DIR_UP: begin
						if (at_top && center_act && !at_bottom) begin
							dir <= DIR_DOWN;
							cnt <= 12'(cnt - 12'h001);
						end else if (at_top) begin
							cnt <= 12'h000;
						end else begin
							cnt <= 12'(cnt + 12'h001);
						end
					end
					DIR_DOWN: begin
						if (at_bottom) begin
							dir <= DIR_UP;
							cnt <= 12'h001;
						end else begin
							cnt <= 12'(cnt - 12'h001);
						end
					end
					default: dir <= DIR_UP;
				endcase
			end
		end
	end

	// Preload registers copied only here, so compare writes never glitch outputs
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			clk_en_q <= 1'b0;
			rep_act <= REP_RST;
			rep_cnt <= REP_RST;
			presc_act <= PRESCALE_RST;
			center_act <= 1'b0;
			byte_act <= 1'b0;
			update_event_o <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				cmp_act[i] <= 13'h0000;
			end
		end else begin
			clk_en_q <= clk_en;
			update_event_o <= upd;
			if (upd) begin
				rep_act <= rep_pre;
				rep_cnt <= rep_pre;
				presc_act <= pwc_pre[2:0];
				center_act <= pwc_pre[PWC_CENTER];
				byte_act <= pwc_pre[PWC_BYTE_MODE];
				for (int i = 0; i < 4; i++) begin
					if (armed[i]) begin
						cmp_act[i] <= pwc_pre[PWC_BYTE_MODE] ? {5'h00, cmp_hi[i]}
							: round13({cmp_hi[i], cmp_lo[i]});
					end
				end
			end else if (wrap) begin
				rep_cnt <= 8'(rep_cnt - 8'h01);
			end
		end
	end

	assign update_interrupt_flag_o = upd_flag;

	// ****************************************
	// Phase levels, routing and chopper
	// ****************************************
	logic [2:0] next_phase;
	logic [5:0] next_motor_out;
	logic chop_wave;

	always_comb begin
		for (int k = 0; k < 3; k++) begin
			next_phase[k] = phase_level(cmp_act[k + 1], cnt, center_act && dir == DIR_DOWN,
				(byte_act && force_bits[k]) || cmp_act[k + 1] > {1'b0, carrier});
		end
		if (!three_sig) begin
			next_phase[2:1] = 2'b00;
		end
	end

	always_comb begin
		for (int k = 0; k < 3; k++) begin
			next_motor_out[2 * k] = phase_o[k] && (!chop_target[1] || chop_wave);
			next_motor_out[2 * k + 1] = (k == 0 || three_sig) && !phase_o[k]
				&& (!chop_target[0] || chop_wave);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			phase_o <= 3'h0;
			motor_output_channel_o <= 6'h00;
		end else begin
			phase_o <= next_phase;
			motor_output_channel_o <= next_motor_out;
		end
	end

	tpc_chop_wave u_chop (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.enable_i(chop_target != 2'b00),
		.half_rate_i(ctrl[CTRL_HALF_RATE]),
		.freq_sel_i(chop_cfg[CHOP_FRQ_LSB +: 3]),
		.wave_o(chop_wave)
	);

	// ****************************************
	// Assertions
	// ****************************************
	chk_stopped_zero: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		!clk_en |=> cnt == 12'h000 && dir == DIR_UP)
		else $error("counter not held at zero while stopped");

	chk_edge_clear: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		clk_en && tick && !center_act && at_top |=> cnt == 12'h000)
		else $error("edge mode counter did not clear at carrier");

	chk_center_turn: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		clk_en && tick && center_act && dir == DIR_UP && at_top && !at_bottom
		|=> dir == DIR_DOWN && cnt == $past(cnt) - 12'h001)
		else $error("center mode did not turn down at carrier");

	chk_zero_low: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		cmp_act[1] == 13'h0000 && !(byte_act && force_bits[0]) |=> !phase_o[0])
		else $error("zero compare did not hold phase low");

	chk_full_high: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		cmp_act[1] > {1'b0, carrier} |=> phase_o[0])
		else $error("compare above carrier did not hold phase high");

	chk_single_route: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		!three_sig |=> phase_o[2:1] == 2'b00)
		else $error("phases V and W routed in single mode");

	chk_chop_off: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		chop_target == 2'b00 |=> motor_output_channel_o[0] == $past(phase_o[0])
		&& motor_output_channel_o[1] == !$past(phase_o[0]))
		else $error("outputs chopped while chopper off");

	chk_preload_hold: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		!upd |=> $stable(cmp_act[1]) && $stable(cmp_act[0]) && $stable(presc_act))
		else $error("active compare changed outside update");

	chk_force_clear: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		upd && !wr_pwc |=> force_bits == 3'h0)
		else $error("force bits survived update event");

	chk_update_flag: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		upd && ctrl[CTRL_UPD_IE] |=> upd_flag && update_event_o)
		else $error("update flag not raised with update");

	chk_arm_high: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		wr_lo[1] && !wr_hi[1] ##1 upd |=> $stable(cmp_act[1]))
		else $error("half written compare was transferred");

endmodule
`default_nettype wire

/* hdl/tpc_pkg.sv */
// Shared constants and types of the three-phase PWM generator.
// Assumes a 10 MHz single clock and an AXI4-Lite register bus.
package tpc_pkg;

	// ****************************************
	// Clock and chopper timing
	// ****************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int CHOP_FREQ_HZ [8] = '{100_000, 200_000, 400_000, 500_000,
		800_000, 1_000_000, 1_333_333, 2_000_000};
	// Half period of each chop wave, rounded down, never below one cycle
	localparam logic [7:0] CHOP_HALF_CYC [8] = '{
		8'(CLK_HZ / (2 * CHOP_FREQ_HZ[0])), 8'(CLK_HZ / (2 * CHOP_FREQ_HZ[1])),
		8'(CLK_HZ / (2 * CHOP_FREQ_HZ[2])), 8'(CLK_HZ / (2 * CHOP_FREQ_HZ[3])),
		8'(CLK_HZ / (2 * CHOP_FREQ_HZ[4])), 8'(CLK_HZ / (2 * CHOP_FREQ_HZ[5])),
		8'(CLK_HZ / (2 * CHOP_FREQ_HZ[6])), 8'(CLK_HZ / (2 * CHOP_FREQ_HZ[7]))};

	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
	localparam logic [31:0] OFS_PWM_CONTROL = 32'h0000_0004;
	localparam logic [31:0] OFS_CHOPPER = 32'h0000_0008;
	localparam logic [31:0] OFS_REPETITION = 32'h0000_000C;
	localparam logic [31:0] OFS_CMP_BASE = 32'h0000_0010;
	localparam logic [31:0] OFS_CMP_STRIDE = 32'h0000_0008;
	localparam logic [31:0] OFS_CMP_HIGH = 32'h0000_0004;
	localparam logic [31:0] OFS_STATUS = 32'h0000_0030;
	localparam logic [31:0] OFS_COUNTER = 32'h0000_0034;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int CTRL_CLK_EN = 0;
	localparam int CTRL_THREE_SIGNAL = 1;
	localparam int CTRL_DEADTIME_EN = 2;
	localparam int CTRL_HALF_RATE = 3;
	localparam int CTRL_UPD_IE = 4;
	localparam int CTRL_W = 5;
	localparam int PWC_CENTER = 3;
	localparam int PWC_BYTE_MODE = 4;
	localparam int PWC_FORCE_LSB = 5;
	localparam int CHOP_TGT_LO = 0;
	localparam int CHOP_TGT_HI = 1;
	localparam int CHOP_FRQ_LSB = 2;
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
	localparam logic [7:0] PWC_RST = 8'h00;
	localparam logic [4:0] CHOP_RST = 5'h00;
	localparam logic [7:0] REP_RST = 8'h00;
	localparam logic [7:0] CMP_BYTE_RST = 8'h00;
	localparam logic [2:0] PRESCALE_RST = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {DIR_UP = 2'b01, DIR_DOWN = 2'b10} tpc_dir_t;

	typedef struct packed {
		logic [31:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [31:0] araddr;
		logic arvalid;
		logic rready;
	} tpc_axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tpc_axil_rsp_t;

endpackage

/* hdl/tpc_chop_wave.sv */
// Square wave source for the high frequency chopper.
// Assumes the 10 MHz reference clock; frequency code may change any time.
`timescale 1ns/100ps
`default_nettype none

module tpc_chop_wave import tpc_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic enable_i,
	input wire logic half_rate_i,
	input wire logic [2:0] freq_sel_i,
	output var logic wave_o
);

	// ****************************************
	// Divider
	// ****************************************
	logic [7:0] div_cnt;
	wire logic [7:0] half_cyc = CHOP_HALF_CYC[freq_sel_i];
	// Slow motor clock halves every frequency
	wire logic [7:0] limit = half_rate_i ? {half_cyc[6:0], 1'b0} : half_cyc;
	wire logic at_limit = (div_cnt >= 8'(limit - 8'h01));

	always_ff @(posedge ref_clk_i) begin
		if (srst_i || !enable_i) begin
			div_cnt <= 8'h00;
			wave_o <= 1'b1;
		end else if (at_limit) begin
			div_cnt <= 8'h00;
			wave_o <= !wave_o;
		end else begin
			div_cnt <= 8'(div_cnt + 8'h01);
		end
	end

endmodule
`default_nettype wire

/* dv/tpc_chan_model.sv */
// Channel manager stand-in: counts high cycles and rising edges per line.
// Assumes the bench strobes the counting window on ref_clk_i.
`timescale 1ns/100ps
`default_nettype none

module tpc_chan_model (
	input wire logic ref_clk_i,
	input wire logic clr_i,
	input wire logic en_i,
	input wire logic [9:0] sig_i,
	output var logic [9:0][11:0] hi_o,
	output var logic [9:0][11:0] rise_o
);
	logic [9:0] last;

	// Edge counts over whole periods do not depend on window phase
	always_ff @(posedge ref_clk_i) begin
		last <= sig_i;
		for (int k = 0; k < 10; k++) begin
			if (clr_i) begin
				hi_o[k] <= 12'h000;
				rise_o[k] <= 12'h000;
			end else if (en_i) begin
				hi_o[k] <= hi_o[k] + 12'(sig_i[k]);
				rise_o[k] <= rise_o[k] + 12'(sig_i[k] & ~last[k]);
			end
		end
	end
endmodule
`default_nettype wire

/* dv/tpc_pwm_gen_bench.sv */
// Self-checking bench of the three-phase PWM generator.
// Assumes AXI4-Lite answers on ref_clk_i at 10 MHz; carrier fixed at 9.
`timescale 1ns/100ps
`default_nettype none

module tpc_pwm_gen_bench import tpc_pkg::*; ();
	logic ref_clk_i = 1'b0;
	logic srst_i = 1'b1;
	tpc_axil_req_t axi_req = '0;
	tpc_axil_rsp_t axi_rsp;
	logic [2:0] phase;
	logic [5:0] mch;
	logic upd_evt;
	logic upd_flag;
	logic clr = 1'b0;
	logic en = 1'b0;
	logic [9:0][11:0] hi;
	logic [9:0][11:0] rise;
	int failures = 0;
	int checks = 0;
	int cycles = 0;

	always #50 ref_clk_i = ~ref_clk_i;

	tpc_pwm_gen dut_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .axi_req_i(axi_req),
		.axi_rsp_o(axi_rsp), .phase_o(phase), .motor_output_channel_o(mch),
		.update_event_o(upd_evt), .update_interrupt_flag_o(upd_flag));

	// Index 0..5 motor lines, 6..8 phases U V W, 9 update pulse
	tpc_chan_model mdl_u (.ref_clk_i(ref_clk_i), .clr_i(clr), .en_i(en),
		.sig_i({upd_evt, phase, mch}), .hi_o(hi), .rise_o(rise));

	// ****************************************
	// Reporting and bus tasks
	// ****************************************
	task automatic close_out();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 30000) begin
			failures++;
			close_out();
		end
	end

	task automatic cmp(input logic [31:0] got, input int exp);
		checks++;
		if (got !== 32'(exp)) begin
			failures++;
			$display("unexpected at %0t ns: got %h expected %h", $time, got, 32'(exp));
		end
	endtask

	// Entered off the previous transfer's edge so no signal is driven twice
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge ref_clk_i);
		axi_req.awaddr <= a;
		axi_req.awvalid <= 1'b1;
		axi_req.wdata <= d;
		axi_req.wstrb <= 4'hF;
		axi_req.wvalid <= 1'b1;
		axi_req.bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge ref_clk_i);
			if (!aw_done && axi_rsp.awready) begin
				aw_done = 1'b1;
				axi_req.awvalid <= 1'b0;
			end
			if (!w_done && axi_rsp.wready) begin
				w_done = 1'b1;
				axi_req.wvalid <= 1'b0;
			end
		end
		while (!axi_rsp.bvalid) @(posedge ref_clk_i);
		cmp(32'(axi_rsp.bresp), int'(er));
		axi_req.bready <= 1'b0;
	endtask

	task automatic rchk(input logic [31:0] a, input int e, input logic [1:0] er);
		@(posedge ref_clk_i);
		axi_req.araddr <= a;
		axi_req.arvalid <= 1'b1;
		axi_req.rready <= 1'b1;
		@(posedge ref_clk_i);
		while (!axi_rsp.arready) @(posedge ref_clk_i);
		axi_req.arvalid <= 1'b0;
		while (!axi_rsp.rvalid) @(posedge ref_clk_i);
		cmp(axi_rsp.rdata, e);
		cmp(32'(axi_rsp.rresp), int'(er));
		axi_req.rready <= 1'b0;
	endtask

	task automatic setc(input int i, input logic [12:0] v);
		logic [15:0] s;
		s = {v, 3'h0};
		wr(OFS_CMP_BASE + OFS_CMP_STRIDE * 32'(i), {24'h0, s[7:0]}, RESP_OKAY);
		wr(OFS_CMP_BASE + OFS_CMP_STRIDE * 32'(i) + OFS_CMP_HIGH, {24'h0, s[15:8]}, RESP_OKAY);
	endtask

	// Stop, program, then enable so every preload lands at once
	task automatic start(input logic [7:0] ctrl, input logic [7:0] pwc, input logic [7:0] rep,
		input logic [12:0] u, input logic [12:0] w);
		wr(OFS_CTRL, 32'h0, RESP_OKAY);
		wr(OFS_PWM_CONTROL, {24'h0, pwc}, RESP_OKAY);
		wr(OFS_REPETITION, {24'h0, rep}, RESP_OKAY);
		setc(0, 13'h0009);
		setc(1, u);
		setc(2, 13'h0000);
		setc(3, w);
		wr(OFS_CTRL, {24'h0, ctrl}, RESP_OKAY);
		repeat (30) @(posedge ref_clk_i);
	endtask

	task automatic meas(input int n);
		@(posedge ref_clk_i);
		clr <= 1'b1;
		@(posedge ref_clk_i);
		clr <= 1'b0;
		en <= 1'b1;
		repeat (n) @(posedge ref_clk_i);
		en <= 1'b0;
		@(posedge ref_clk_i);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		rchk(OFS_CTRL, 0, RESP_OKAY);
		rchk(OFS_PWM_CONTROL, 0, RESP_OKAY);
		rchk(OFS_CHOPPER, 0, RESP_OKAY);
		rchk(OFS_STATUS, 0, RESP_OKAY);
		rchk(32'h0000_0040, 0, RESP_SLVERR);
		wr(32'h0000_0040, 32'h0000_00FF, RESP_SLVERR);
		setc(0, 13'h0009);
		rchk(OFS_CMP_BASE, 'h48, RESP_OKAY);
		repeat (20) @(posedge ref_clk_i);
		rchk(OFS_COUNTER, 0, RESP_OKAY);
	endtask

	task automatic t_edge();
		start(8'h13, 8'h00, 8'h00, 13'h0003, 13'h1FFF);
		cmp(32'(upd_flag), 1);
		meas(100);
		cmp(hi[6], 30);
		cmp(hi[7], 0);
		cmp(hi[8], 100);
		cmp(hi[1], 70);
		cmp(rise[6], 10);
		cmp(rise[9], 10);
		wr(OFS_CMP_BASE + 32'h8, 32'h1C, RESP_OKAY);
		repeat (30) @(posedge ref_clk_i);
		meas(100);
		cmp(hi[6], 30);
		wr(OFS_CMP_BASE + 32'hC, 32'h00, RESP_OKAY);
		repeat (30) @(posedge ref_clk_i);
		meas(100);
		cmp(hi[6], 40);
	endtask

	task automatic t_modes();
		start(8'h13, 8'h01, 8'h01, 13'h0003, 13'h0000);
		meas(200);
		cmp(hi[6], 60);
		cmp(rise[9], 5);
		start(8'h13, 8'h08, 8'h00, 13'h0003, 13'h1FFF);
		meas(180);
		cmp(hi[6], 60);
		cmp(rise[6], 10);
		cmp(rise[9], 20);
		cmp(hi[8], 180);
		wr(OFS_CTRL, 32'h0, RESP_OKAY);
		wr(OFS_STATUS, 32'h1, RESP_OKAY);
		start(8'h01, 8'h00, 8'h00, 13'h0003, 13'h1FFF);
		cmp(32'(upd_flag), 0);
		meas(100);
		cmp(hi[6], 30);
		cmp(hi[8], 0);
		cmp(hi[5] | hi[4] | hi[3] | hi[2], 0);
		wr(OFS_CTRL, 32'h11, RESP_OKAY);
		repeat (30) @(posedge ref_clk_i);
		rchk(OFS_STATUS, 1, RESP_OKAY);
		wr(OFS_CTRL, 32'h0, RESP_OKAY);
		repeat (30) @(posedge ref_clk_i);
		rchk(OFS_COUNTER, 0, RESP_OKAY);
	endtask

	task automatic t_byte();
		wr(OFS_PWM_CONTROL, 32'h10, RESP_OKAY);
		wr(OFS_CMP_BASE + 32'h04, 32'h09, RESP_OKAY);
		wr(OFS_CMP_BASE + 32'h0C, 32'h03, RESP_OKAY);
		wr(OFS_CMP_BASE + 32'h14, 32'h02, RESP_OKAY);
		wr(OFS_CMP_BASE + 32'h1C, 32'h00, RESP_OKAY);
		wr(OFS_CTRL, 32'h13, RESP_OKAY);
		repeat (30) @(posedge ref_clk_i);
		meas(100);
		cmp(hi[6], 30);
		cmp(hi[7], 20);
		wr(OFS_CTRL, 32'h02, RESP_OKAY);
		wr(OFS_PWM_CONTROL, 32'h90, RESP_OKAY);
		meas(20);
		cmp(hi[8], 20);
		wr(OFS_CTRL, 32'h13, RESP_OKAY);
		repeat (30) @(posedge ref_clk_i);
		rchk(OFS_PWM_CONTROL, 'h10, RESP_OKAY);
	endtask

	task automatic t_chop();
		start(8'h13, 8'h00, 8'h00, 13'h0000, 13'h1FFF);
		for (int t = 0; t < 4; t++) begin
			wr(OFS_CHOPPER, 32'h1C | 32'(t), RESP_OKAY);
			repeat (20) @(posedge ref_clk_i);
			meas(600);
			cmp(hi[1], (t & 1) ? 300 : 600);
			cmp(hi[4], (t & 2) ? 300 : 600);
			cmp(hi[0] | hi[5], 0);
		end
		// Window of 600 holds whole chop periods for every code
		for (int f = 0; f < 8; f++) begin
			wr(OFS_CHOPPER, 32'(f * 4 + 3), RESP_OKAY);
			repeat (120) @(posedge ref_clk_i);
			meas(600);
			cmp(rise[4], 600 / (2 * int'(CHOP_HALF_CYC[f])));
		end
		wr(OFS_CTRL, 32'h1B, RESP_OKAY);
		repeat (120) @(posedge ref_clk_i);
		meas(600);
		cmp(rise[4], 600 / (4 * int'(CHOP_HALF_CYC[7])));
	endtask

	initial begin
		repeat (10) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		t_regs();
		t_edge();
		t_modes();
		t_byte();
		t_chop();
		close_out();
	end
endmodule
`default_nettype wire
